// File: rtl/spi_cfg.sv
/*
 serial port configuration: control registers, bit rate prescaler
 and divider, flags register, pin steering and interrupt logic.
 assumes a transfer engine outside supplies flag events and data bits;
 the bus master follows APB; pins are synchronised here.
*/
`timescale 1ns/1ns
`include "spi_cfg_params.svh"
//
// Contract
// - control two is read/write; bits 7,6,5,2 read zero.
// - as slave, mode fault enable ignored; select pin is select input.
// - master, fault enable 0 frees select pin; 1 uses it.
// - single wire: output enable 0 makes pin input, 1 drives it.
// - without single wire, output enable has no effect.
// - single wire: slave uses MISO, master uses MOSI.
// - single wire bit 0 means separate data in and out pins.
// - stop in wait 1 halts clocks in wait; 0 keeps running.
// - bit rate register readable and writable at any time.
// - prescale field bits 6:4 divides bus clock by value plus one.
// - rate field bits 2:0 divides by two to power value plus one.
// - divider fed by prescaler; output is master bit clock.
// - flags register: three read only flags, others zero, writes ignored.
// - master with fault enable: select output enable picks input or output.
// - receive full bit 7, transmit empty bit 5, mode fault bit 4.
module spi_cfg
(
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               wait_mode,
	input  wire logic               xfer_active,
	input  wire logic               master_out_bit,
	input  wire logic               slave_out_bit,
	input  wire logic               select_drive,
	input  wire spi_cfg_pkg::flags_t flag_set,
	input  wire spi_cfg_pkg::flags_t flag_clr,
	input  wire logic               mosi_i,
	output logic                    mosi_o,
	output logic                    mosi_oe,
	input  wire logic               miso_i,
	output logic                    miso_o,
	output logic                    miso_oe,
	input  wire logic               ss_n_i,
	output logic                    ss_n_o,
	output logic                    ss_n_oe,
	output logic                    data_in_bit,
	output logic                    select_active,
	output logic                    fault_input_low,
	output logic                    port_clk_en,
	output logic                    bit_clk_tick,
	output logic                    bit_clk,
	output logic                    irq
);
	import spi_cfg_pkg::*;
	localparam logic [2:0] sync_init = `SYNC_RESET;

	logic [7:0]  ctrl_one_q;
	logic [7:0]  ctrl_two_q;
	logic [7:0]  bit_rate_q;
	flags_t      flags_q;
	logic [2:0]  irq_status_q;
	logic [2:0]  irq_mask_q;
	logic [2:0]  pre_cnt_q;
	logic [7:0]  div_cnt_q;
	logic        bit_clk_q;
	div_state_t  div_state_q;
	logic [2:0]  pin_raw;
	logic [2:0]  meta_q;
	logic [2:0]  pin_sync_q;
	logic        mosi_s;
	logic        miso_s;
	logic        ss_n_s;
	logic        sts_clr_wr;
	logic        is_master;
	logic        mode_fault_flag_en;
	logic        bidir_oe;
	logic        single_wire;
	logic        wr_en;
	logic        pre_tick;
	logic [7:0]  div_last;
	logic [31:0] rd_mux;
	logic        addr_ok;
	pin_drive_t  mosi_drv;
	pin_drive_t  miso_drv;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction

	assign is_master   = ctrl_one_q[`C1_MASTER];
	assign mode_fault_flag_en     = ctrl_two_q[`C2_MODE_FAULT_FLAG_EN];
	assign bidir_oe    = ctrl_two_q[`C2_BIDIR_OE];
	assign single_wire = ctrl_two_q[`C2_SINGLE_WIRE];
	assign wr_en       = psel & penable & pwrite;
	assign pready      = 1'b1;
	assign addr_ok     = hit(paddr, `OFS_CTRL_ONE) | hit(paddr, `OFS_CTRL_TWO)
		| hit(paddr, `OFS_BIT_RATE) | hit(paddr, `OFS_FLAGS)
		| hit(paddr, `OFS_IRQ_STATUS) | hit(paddr, `OFS_IRQ_MASK);
	assign pslverr     = psel & penable & ~addr_ok;

	// control registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_one_q <= `CTRL_RESET;
			ctrl_two_q <= `CTRL_RESET;
		end
		else if (wr_en)
		begin
			if (hit(paddr, `OFS_CTRL_ONE))
				ctrl_one_q <= pwdata[7:0] & `C1_WMASK;
			if (hit(paddr, `OFS_CTRL_TWO))
				ctrl_two_q <= pwdata[7:0] & `C2_WMASK;
		end
	end

	// bit rate register, writable even mid transfer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bit_rate_q <= `BR_RESET;
		else if (wr_en && hit(paddr, `OFS_BIT_RATE))
			bit_rate_q <= pwdata[7:0] & `BR_WMASK;
	end

	// flags, set by engine; set wins over clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flags_q <= `FLAGS_RESET;
		else
			flags_q <= flag_set | (flags_q & ~flag_clr);
	end

	// sticky interrupt status, one bit per event; set wins over clear
	assign sts_clr_wr = wr_en && hit(paddr, `OFS_IRQ_STATUS);

	generate
		for (genvar b = 0; b < `IRQ_BITS; b = b + 1)
		begin : g_sts
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					irq_status_q[b] <= 1'b0;
				else if (flag_set[b])
					irq_status_q[b] <= 1'b1;
				else if (sts_clr_wr && pwdata[b])
					irq_status_q[b] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_mask_q <= 3'b000;
		else if (wr_en && hit(paddr, `OFS_IRQ_MASK))
			irq_mask_q <= pwdata[2:0];
	end

	// a set mask bit holds its event back
	assign irq = |(irq_status_q & ~irq_mask_q);

	// read mux; flags register ignores writes
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (hit(paddr, `OFS_CTRL_ONE))
			rd_mux[7:0] = ctrl_one_q;
		if (hit(paddr, `OFS_CTRL_TWO))
			rd_mux[7:0] = ctrl_two_q;
		if (hit(paddr, `OFS_BIT_RATE))
			rd_mux[7:0] = bit_rate_q;
		if (hit(paddr, `OFS_FLAGS))
		begin
			rd_mux[`FLG_RX_FULL]    = flags_q.rx_full;
			rd_mux[`FLG_TX_EMPTY]   = flags_q.tx_empty;
			rd_mux[`FLG_MODE_FAULT] = flags_q.mode_fault;
		end
		if (hit(paddr, `OFS_IRQ_STATUS))
			rd_mux[2:0] = irq_status_q;
		if (hit(paddr, `OFS_IRQ_MASK))
			rd_mux[2:0] = irq_mask_q;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= rd_mux;
	end

	// clock gating for wait mode
	assign port_clk_en = ~(wait_mode & ctrl_two_q[`C2_STOP_WAIT]);

	// prescaler: divide by field plus one
	assign pre_tick = port_clk_en && (pre_cnt_q == bit_rate_q[6:4]);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pre_cnt_q <= 3'h0;
		else if (!port_clk_en)
			pre_cnt_q <= pre_cnt_q;
		else if (pre_tick)
			pre_cnt_q <= 3'h0;
		else
			pre_cnt_q <= pre_cnt_q + 3'h1;
	end

	// divider: half period of 2^field prescaler ticks
	assign div_last = 8'((9'h001 << bit_rate_q[2:0]) - 9'h001);

	// run state follows master select and the port clock gate
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_state_q <= DIV_IDLE;
		else
			case (div_state_q)
				DIV_IDLE:
					if (is_master)
						div_state_q <= DIV_RUN;
				DIV_RUN:
					if (!is_master)
						div_state_q <= DIV_IDLE;
					else if (!port_clk_en)
						div_state_q <= DIV_HALT;
				DIV_HALT:
					if (port_clk_en)
						div_state_q <= DIV_RUN;
				default: div_state_q <= DIV_IDLE;
			endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_cnt_q <= 8'h00;
			bit_clk_q <= 1'b0;
		end
		else if (div_state_q != DIV_RUN)
		begin
			div_cnt_q <= 8'h00;
			bit_clk_q <= bit_clk_q;
		end
		else if (pre_tick)
		begin
			if (div_cnt_q >= div_last)
			begin
				div_cnt_q <= 8'h00;
				bit_clk_q <= ~bit_clk_q;
			end
			else
				div_cnt_q <= div_cnt_q + 8'h01;
		end
	end

	assign bit_clk      = bit_clk_q;
	assign bit_clk_tick = (div_state_q == DIV_RUN) && pre_tick
		&& (div_cnt_q >= div_last) && bit_clk_q;

	// pin synchronisers; only the second stage feeds logic
	assign pin_raw = {mosi_i, miso_i, ss_n_i};

	generate
		for (genvar s = 0; s < 3; s = s + 1)
		begin : g_sync
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					meta_q[s]     <= sync_init[s];
					pin_sync_q[s] <= sync_init[s];
				end
				else
				begin
					meta_q[s]     <= pin_raw[s];
					pin_sync_q[s] <= meta_q[s];
				end
			end
		end
	endgenerate

	assign mosi_s = pin_sync_q[2];
	assign miso_s = pin_sync_q[1];
	assign ss_n_s = pin_sync_q[0];

	// data pin steering
	always_comb
	begin
		mosi_drv = '{o: 1'b0, oe: 1'b0};
		miso_drv = '{o: 1'b0, oe: 1'b0};
		data_in_bit = 1'b0;
		if (!single_wire)
		begin
			if (is_master)
			begin
				mosi_drv    = '{o: master_out_bit, oe: 1'b1};
				data_in_bit = miso_s;
			end
			else
			begin
				miso_drv    = '{o: slave_out_bit, oe: select_active};
				data_in_bit = mosi_s;
			end
		end
		else if (is_master)
		begin
			mosi_drv    = '{o: master_out_bit, oe: bidir_oe};
			data_in_bit = mosi_s;
		end
		else
		begin
			miso_drv    = '{o: slave_out_bit, oe: bidir_oe};
			data_in_bit = miso_s;
		end
	end

	assign mosi_o  = mosi_drv.o;
	assign mosi_oe = mosi_drv.oe;
	assign miso_o  = miso_drv.o;
	assign miso_oe = miso_drv.oe;

	// select pin function
	assign select_active   = ~is_master & ~ss_n_s;
	assign fault_input_low = is_master & mode_fault_flag_en & ~ctrl_one_q[`C1_SEL_OE]
		& ~ss_n_s;
	assign ss_n_oe = is_master & mode_fault_flag_en & ctrl_one_q[`C1_SEL_OE];
	// automatic select output, low while the engine shifts and select_drive is high
	assign ss_n_o  = ~(select_drive & xfer_active);
endmodule

// File: rtl/spi_cfg_params.svh
/*
 register offsets, field positions, write masks and reset values
 for the serial port configuration block; included by the design.
*/
`ifndef SPI_CFG_PARAMS_SVH
`define SPI_CFG_PARAMS_SVH
`define OFS_CTRL_ONE    12'h000
`define OFS_CTRL_TWO    12'h004
`define OFS_BIT_RATE    12'h008
`define OFS_FLAGS       12'h00C
`define OFS_IRQ_STATUS  12'h010
`define OFS_IRQ_MASK    12'h014
`define C2_WMASK        8'h1B
`define C2_MODE_FAULT_FLAG_EN      4
`define C2_BIDIR_OE     3
`define C2_STOP_WAIT    1
`define C2_SINGLE_WIRE  0
`define C1_MASTER       4
`define C1_SEL_OE       1
`define C1_WMASK        8'h12
`define BR_WMASK        8'h77
`define FLG_RX_FULL     7
`define FLG_TX_EMPTY    5
`define FLG_MODE_FAULT  4
`define CTRL_RESET      8'h00
`define BR_RESET        8'h00
`define IRQ_BITS        3
`define FLAGS_RESET     3'h2
`define SYNC_RESET      3'h1
`endif

// File: rtl/spi_cfg_pkg.sv
/*
 types shared by the serial port configuration block.
 assumes the params header supplies the numeric constants.
*/
package spi_cfg_pkg;
	typedef struct packed {
		logic rx_full;
		logic tx_empty;
		logic mode_fault;
	} flags_t;
	typedef struct packed {
		logic o;
		logic oe;
	} pin_drive_t;
	typedef enum logic [1:0] {
		DIV_IDLE = 2'b00,
		DIV_RUN  = 2'b01,
		DIV_HALT = 2'b11
	} div_state_t;
endpackage

// File: tb/spi_cfg_asserts.sv
/* port relations of the serial port configuration block.
 bound to every spi_cfg instance. */
`timescale 1ns/1ns
`include "spi_cfg_params.svh"
module spi_cfg_asserts
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        wait_mode,
	input wire logic        xfer_active,
	input wire logic        select_drive,
	input wire logic        mosi_oe,
	input wire logic        miso_oe,
	input wire logic        ss_n_o,
	input wire logic        ss_n_oe,
	input wire logic        select_active,
	input wire logic        fault_input_low,
	input wire logic        port_clk_en,
	input wire logic        bit_clk
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic rd;
	assign rd = psel && penable && !pwrite;
	property p_rdy; psel |-> pready; endproperty
	property p_c2; rd && paddr == `OFS_CTRL_TWO |-> !(prdata & ~32'h1B);
	endproperty
	property p_br; rd && paddr == `OFS_BIT_RATE |-> !(prdata & ~32'h77);
	endproperty
	property p_flg; rd && paddr == `OFS_FLAGS |-> !(prdata & ~32'hB0);
	endproperty
	property p_pins; !(mosi_oe && miso_oe); endproperty
	property p_flt; fault_input_low |-> !ss_n_oe && !select_active;
	endproperty
	property p_ss; ss_n_oe |-> ss_n_o == !(select_drive && xfer_active);
	endproperty
	property p_run; !wait_mode |-> port_clk_en; endproperty
	property p_halt; !port_clk_en [*2] |=> $stable(bit_clk); endproperty
	a_rdy: assert property (p_rdy) else $error("pready low");
	a_c2: assert property (p_c2) else $error("c2 stray bits");
	a_br: assert property (p_br) else $error("br stray bits");
	a_flg: assert property (p_flg) else $error("flag stray bits");
	a_pins: assert property (p_pins) else $error("two drivers");
	a_flt: assert property (p_flt) else $error("fault pin out");
	a_ss: assert property (p_ss) else $error("select not low");
	a_run: assert property (p_run) else $error("clock halted");
	a_halt: assert property (p_halt) else $error("bit clock ran");
	c_flg: cover property (rd && paddr == `OFS_FLAGS);
	c_flt: cover property (fault_input_low);
	c_halt: cover property (!port_clk_en);
	c_ss: cover property (ss_n_oe && !ss_n_o);
endmodule
bind spi_cfg spi_cfg_asserts spi_cfg_asserts_inst (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .wait_mode, .xfer_active,
	.select_drive, .mosi_oe, .miso_oe, .ss_n_o, .ss_n_oe, .select_active,
	.fault_input_low, .port_clk_en, .bit_clk);

// File: tb/spi_peer.sv
/* far side device on the serial pins.
 resolves each pin from the design and peer drivers. */
`timescale 1ns/1ns
module spi_peer
(
	input  wire logic pclk,
	input  wire logic peer_bit,
	input  wire logic ss_req_n,
	input  wire logic mosi_o,
	input  wire logic mosi_oe,
	input  wire logic miso_o,
	input  wire logic miso_oe,
	input  wire logic ss_n_o,
	input  wire logic ss_n_oe,
	output logic      mosi_i,
	output logic      miso_i,
	output logic      ss_n_i
);
	logic fill_q = 1'b0;
	always @(posedge pclk) fill_q <= ~fill_q;
	// peer drives data onto whichever line is free
	assign mosi_i = mosi_oe ? mosi_o : peer_bit;
	assign miso_i = miso_oe ? miso_o : peer_bit ^ fill_q;
	assign ss_n_i = ss_n_oe ? ss_n_o : ss_req_n;
endmodule

// File: tb/testbench.sv
/* self checking bench for spi_cfg.
 assumes the checker is bound and the peer sits on the pins. */
`timescale 1ns/1ns
`include "spi_cfg_params.svh"
module testbench;
	import spi_cfg_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q, d;
	logic pready, pslverr, err, wait_mode = 0, xfer_active = 0;
	logic mob = 0, sob = 0, sel_drv = 0, pb = 0, ss_req_n = 1;
	flags_t flag_set = 0, flag_clr = 0;
	logic mosi_i, mosi_o, mosi_oe, miso_i, miso_o, miso_oe;
	logic ss_n_i, ss_n_o, ss_n_oe, din, sel_act, flt, clk_en, tick, bclk, irq;
	integer seed = 30, mismatches = 0, comparisons = 0, cyc = 0, i, n;
	logic [4:0] k = 0;
	logic [1:0] din_h = 0, dx;
	logic [2:0] p, r;
	spi_cfg spi_cfg_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .wait_mode, .xfer_active,
		.master_out_bit(mob), .slave_out_bit(sob), .select_drive(sel_drv),
		.flag_set, .flag_clr, .mosi_i, .mosi_o, .mosi_oe, .miso_i, .miso_o,
		.miso_oe, .ss_n_i, .ss_n_o, .ss_n_oe, .data_in_bit(din),
		.select_active(sel_act), .fault_input_low(flt), .port_clk_en(clk_en),
		.bit_clk_tick(tick), .bit_clk(bclk), .irq);
	spi_peer spi_peer_inst (.pclk, .peer_bit(pb), .ss_req_n, .mosi_o, .mosi_oe,
		.miso_o, .miso_oe, .ss_n_o, .ss_n_oe, .mosi_i, .miso_i, .ss_n_i);
	initial forever #10 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		{mob, sob, pb, sel_drv} <= 4'($random(seed));
		din_h <= {din_h[0], (k[4] ^ k[0]) ? miso_i : mosi_i};
		if (cyc == 90000)
		begin
			mismatches++;
			close_out;
		end
	end
	task close_out;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] ex, input logic [31:0] got);
		comparisons++;
		if (got !== ex)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", s, ex, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// {mosi_oe, miso_oe, ss_n_oe} for k = {master, sel_oe, fault_en, bidir, sw}
	function automatic logic [2:0] pins(input logic [4:0] c);
		pins[2] = c[4] & (~c[0] | c[1]);
		pins[1] = ~c[4] & (~c[0] | c[1]);
		pins[0] = c[4] & c[2] & c[3];
	endfunction
	task automatic measure(input logic [2:0] ps, input logic [2:0] rs);
		apb(1, `OFS_BIT_RATE, {25'h0, ps, 1'b0, rs});
		repeat (2) @(posedge pclk iff tick === 1'b1);
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (tick !== 1'b1);
		chk("period", (ps + 1) << (rs + 1), n);
	endtask
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, `OFS_CTRL_TWO, 0);
		chk("c2 reset", 0, q);
		apb(1, `OFS_FLAGS, 32'hFF);
		apb(0, `OFS_FLAGS, 0);
		chk("flags", 32'h20, q);
		apb(0, 12'h018, 0);
		chk("unmapped", 1, err);
		for (i = 0; i < 8; i++)
		begin
			d = $random(seed);
			apb(1, `OFS_CTRL_TWO, d);
			apb(0, `OFS_CTRL_TWO, 0);
			chk("c2", d & 32'h1B, q);
			apb(1, `OFS_BIT_RATE, d);
			apb(0, `OFS_BIT_RATE, 0);
			chk("br", d & 32'h77, q);
		end
		ss_req_n <= 1'b0;
		xfer_active <= 1'b1;
		for (i = 0; i < 32; i++)
		begin
			k = i[4:0];
			apb(1, `OFS_CTRL_ONE, {27'h0, k[4], 2'b00, k[3], 1'b0});
			apb(1, `OFS_CTRL_TWO, {27'h0, k[2], k[1], 2'b00, k[0]});
			repeat (3) @(posedge pclk);
			@(negedge pclk);
			dx = {k[4] & mob, ~k[4] & sob};
			chk("pins", pins(k), {mosi_oe, miso_oe, ss_n_oe});
			chk("fault", k[4] & k[2] & ~k[3], flt);
			chk("sel", {31'h0, ~k[4]}, sel_act);
			chk("dout", dx, {mosi_o, miso_o});
			chk("din", din_h[1], din);
			@(posedge pclk);
		end
		apb(1, `OFS_CTRL_ONE, 32'h10);
		apb(1, `OFS_CTRL_TWO, 0);
		for (i = 0; i < 6; i++)
		begin
			{p, r} = 6'($random(seed));
			measure(p, {1'b0, r[1:0]});
		end
		measure(3'h7, 3'h7);
		measure(3'h0, 3'h0);
		wait_mode <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("run in wait", 1, clk_en);
		wait_mode <= 1'b0;
		apb(1, `OFS_CTRL_TWO, 32'h02);
		wait_mode <= 1'b1;
		repeat (2) @(posedge pclk);
		d = bclk;
		chk("halt in wait", 0, clk_en);
		repeat (20) @(posedge pclk);
		chk("bit clock still", d, bclk);
		wait_mode <= 1'b0;
		flag_set <= 3'b111;
		@(posedge pclk);
		flag_set <= 3'b000;
		apb(0, `OFS_FLAGS, 0);
		chk("flags set", 32'hB0, q);
		apb(0, `OFS_IRQ_STATUS, 0);
		chk("irq status", 32'h7, q);
		chk("irq on", 1, irq);
		apb(1, `OFS_IRQ_MASK, 32'h7);
		chk("irq masked", 0, irq);
		apb(1, `OFS_IRQ_MASK, 0);
		chk("irq unmasked", 1, irq);
		apb(1, `OFS_IRQ_STATUS, 32'h7);
		chk("irq cleared", 0, irq);
		flag_clr <= 3'b111;
		@(posedge pclk);
		flag_clr <= 3'b000;
		apb(0, `OFS_FLAGS, 0);
		chk("flags clr", 0, q);
		close_out;
	end
endmodule
